// file: dma_channel_control.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
// What this block does
// - request source comes from five-bit field, bits 20 to 16
// - code zero and codes 13,14,16,29,30 give no request
// - codes 1-10 serial tx/rx, 11-12 converters, 15 can receive
// - codes 17-20 capture, 21-28 timer compares, 31 auto-request
// - source mode holds, increments or decrements by unit size
// - indirect mode: channel 3 source holds address of data address
// - indirect source pointer steps by four or zero, any size
// - destination mode holds, increments or decrements by unit size
// - unit size field: byte, word, longword; byte at reset
// - bus mode bit 3: cycle-steal at 0, burst at 1
// - end flag set when count done; interrupt if enabled
// - interrupt enable 0 means no interrupt on completion
// - early stop by nmi, address error or enables leaves flag clear
// - end flag set blocks transfers despite channel enable
// - end flag cleared only by 0 write after 1 read, reset or standby
// - auto-request starts as soon as channel enabled
// - peripheral source starts only on a request after enable
// - clearing channel enable suspends the running transfer
// - enabled only with enable, master enable, no flags
// - indirect select works on channel 3 only, else reads 0
// - count decrements per unit; end at zero
// - address error or nmi flag suspends all transfers
module dma_channel_control
  import dma_channel_pkg::*;
#(
  parameter int CHANNEL = 3
) (
  // apb slave
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // peripheral requests and system events, asynchronous
  input  wire logic [NUM_PERIPH-1:0] periph_req,
  input  wire logic             nmi_event,
  input  wire logic             standby,
  // system bus master
  output sysbus_req_t           bus_req,
  input  wire logic             bus_done,
  input  wire logic             bus_addr_err,
  input  wire logic [31:0]      bus_rdata,
  output logic      [31:0]      bus_wdata,
  // completion interrupt
  output logic                  end_irq
);

  chan_state_t s_reg, s_next;
  logic [NUM_PERIPH-1:0] preq_m, preq_s;
  logic [1:0] nmi_m, nmi_s, stb_m, stb_s;

  ////////////////////////////////////////////////////////////////
  // decode a request code to a peripheral line index, -1 for none
  function automatic int src_index(input logic [4:0] code);
    if (code >= 5'h01 && code <= 5'h0C) return int'(code) - 1;
    if (code == 5'h0F) return 12;
    if (code >= 5'h11 && code <= 5'h1C) return int'(code) - 4;
    return -1;
  endfunction : src_index

  // address after one step, in bytes of the unit size, for a mode
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] mode,
                                            input logic [1:0] size);
    logic [31:0] d;
    d = (size == SIZE_LONG) ? 32'h4 : (size == SIZE_WORD) ? 32'h2 : 32'h1;
    unique case (mode)
      STEP_INC: return a + d;
      STEP_DEC: return a - d;
      default:  return a;   // hold, prohibited code treated as hold
    endcase
  endfunction : step_addr

  ////////////////////////////////////////////////////////////////
  // two-stage synchronisers for outside inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      preq_m <= '0;
      preq_s <= '0;
      nmi_m  <= 2'h0;
      nmi_s  <= 2'h0;
      stb_m  <= 2'h0;
      stb_s  <= 2'h0;
    end else begin
      preq_m <= periph_req;
      preq_s <= preq_m;
      // bit 0 of each _m pair is the first flop and bit 1 of each _s pair the
      // second; the spare bits stay 0, and only the second flop feeds the
      // flags, so a first stage caught mid-swing never reaches them
      nmi_m  <= {1'b0, nmi_event};
      nmi_s  <= {nmi_m[0], 1'b0};
      stb_m  <= {1'b0, standby};
      stb_s  <= {stb_m[0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////
  logic wr_acc, rd_acc, xfer_ok, req_now, unit_done, is_auto;
  logic [31:0] ctrl_word;
  int          idx;

  always_comb begin
    s_next   = s_reg;
    wr_acc   = psel && penable && pwrite;
    rd_acc   = psel && penable && !pwrite;
    idx      = src_index(s_reg.ctrl.req_src_sel);
    is_auto  = (s_reg.ctrl.req_src_sel == RS_AUTO);
    unit_done = 1'b0;
    // read view; reserved bits stay zero
    ctrl_word = '0;
    ctrl_word[IND_BIT] = (CHANNEL == 3) ? s_reg.ctrl.indirect_select : 1'b0;
    ctrl_word[RS_LSB+:5]  = s_reg.ctrl.req_src_sel;
    ctrl_word[SM_LSB+:2]  = s_reg.ctrl.src_step_mode;
    ctrl_word[DM_LSB+:2]  = s_reg.ctrl.dst_step_mode;
    ctrl_word[TS_LSB+:2]  = s_reg.ctrl.unit_size;
    ctrl_word[BUSMODE_BIT] = s_reg.ctrl.bus_mode_select;
    ctrl_word[IRQEN_BIT]  = s_reg.ctrl.end_irq_enable;
    ctrl_word[TEND_BIT]   = s_reg.ctrl.transfer_end_flag;
    ctrl_word[CHEN_BIT]   = s_reg.ctrl.channel_enable;
    // transfer-enabled condition
    xfer_ok = s_reg.ctrl.channel_enable && !s_reg.ctrl.transfer_end_flag
              && s_reg.master_enable && !s_reg.nmi_flag
              && !s_reg.addr_error_flag;
    // peripheral request level seen while enabled, latched until served
    if (idx >= 0 && preq_s[idx] && s_reg.ctrl.channel_enable) begin
      s_next.req_pend = 1'b1;
    end
    if (!s_reg.ctrl.channel_enable || idx < 0) begin
      s_next.req_pend = 1'b0;
    end
    req_now = is_auto || s_reg.req_pend;

    // apb response, zero wait states
    s_next.pready  = psel && !penable;
    s_next.pslverr = 1'b0;
    s_next.prdata  = s_reg.prdata;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        CTRL_OFS:   s_next.prdata = ctrl_word;
        SRC_OFS:    s_next.prdata = s_reg.src_addr;
        DST_OFS:    s_next.prdata = s_reg.dst_addr;
        CNT_OFS:    s_next.prdata = {8'h00, s_reg.count};
        GLOBAL_OFS: s_next.prdata = {29'h0, s_reg.addr_error_flag, s_reg.nmi_flag,
                                     s_reg.master_enable};
        default:    s_next.prdata = 32'h0;
      endcase
      s_next.pslverr = !(paddr inside {CTRL_OFS, SRC_OFS, DST_OFS, CNT_OFS, GLOBAL_OFS});
    end
    // a read showing a set flag arms its clear
    if (rd_acc && s_reg.pready && paddr == CTRL_OFS && s_reg.ctrl.transfer_end_flag) begin
      s_next.tend_seen = 1'b1;
    end
    if (rd_acc && s_reg.pready && paddr == GLOBAL_OFS) begin
      s_next.ae_seen  = s_reg.addr_error_flag;
      s_next.nmi_seen = s_reg.nmi_flag;
    end
    if (wr_acc && s_reg.pready) begin
      unique case (paddr)
        CTRL_OFS: begin
          s_next.ctrl.indirect_select = (CHANNEL == 3) && pwdata[IND_BIT];
          s_next.ctrl.req_src_sel     = pwdata[RS_LSB+:5];
          s_next.ctrl.src_step_mode   = pwdata[SM_LSB+:2];
          s_next.ctrl.dst_step_mode   = pwdata[DM_LSB+:2];
          s_next.ctrl.unit_size       = pwdata[TS_LSB+:2];
          s_next.ctrl.bus_mode_select = pwdata[BUSMODE_BIT];
          s_next.ctrl.end_irq_enable  = pwdata[IRQEN_BIT];
          s_next.ctrl.channel_enable  = pwdata[CHEN_BIT];
          // only 0 after a read of 1 clears; 1 is ignored
          if (!pwdata[TEND_BIT] && s_reg.tend_seen) begin
            s_next.ctrl.transfer_end_flag = 1'b0;
          end
          s_next.tend_seen = 1'b0;
          // a new setting never inherits a request latched under the old one
          s_next.req_pend = 1'b0;
        end
        SRC_OFS: s_next.src_addr = pwdata;
        DST_OFS: s_next.dst_addr = pwdata;
        CNT_OFS: s_next.count    = pwdata[CNT_W-1:0];
        GLOBAL_OFS: begin
          s_next.master_enable = pwdata[MEN_BIT];
          if (!pwdata[AE_BIT] && s_reg.ae_seen) s_next.addr_error_flag = 1'b0;
          if (!pwdata[NMI_BIT] && s_reg.nmi_seen) s_next.nmi_flag = 1'b0;
          s_next.ae_seen  = 1'b0;
          s_next.nmi_seen = 1'b0;
        end
        default: ;
      endcase
    end
    // hardware sets win over software clears
    if (nmi_s[1]) s_next.nmi_flag = 1'b1;

    ////////////////////////////////////////////////////////////////
    // transfer sequencer: pointer fetch, read, write
    unique case (s_reg.state)
      ST_IDLE: begin
        if (xfer_ok && req_now) begin
          s_next.req_pend = 1'b0;
          s_next.bus.valid = 1'b1;
          s_next.bus.write = 1'b0;
          s_next.bus.hold  = s_reg.ctrl.bus_mode_select;
          if (CHANNEL == 3 && s_reg.ctrl.indirect_select) begin
            s_next.bus.addr = s_reg.src_addr;
            s_next.bus.size = SIZE_LONG;
            s_next.state    = ST_PTR;
          end else begin
            s_next.bus.addr = s_reg.src_addr;
            s_next.bus.size = s_reg.ctrl.unit_size;
            s_next.state    = ST_READ;
          end
        end
      end
      ST_PTR: if (bus_done) begin
        s_next.bus.addr = bus_rdata;
        s_next.bus.size = s_reg.ctrl.unit_size;
        s_next.state    = ST_READ;
      end
      ST_READ: if (bus_done) begin
        s_next.data      = bus_rdata;
        s_next.bus.write = 1'b1;
        s_next.bus.addr  = s_reg.dst_addr;
        s_next.state     = ST_WRITE;
      end
      ST_WRITE: if (bus_done) begin
        unit_done = 1'b1;
        s_next.bus.valid = 1'b0;
        s_next.bus.write = 1'b0;
        s_next.state     = ST_IDLE;
      end
      default: ;
    endcase

    // per-unit bookkeeping after the bus pair
    if (unit_done) begin
      if (CHANNEL == 3 && s_reg.ctrl.indirect_select) begin
        s_next.src_addr = step_addr(s_reg.src_addr, s_reg.ctrl.src_step_mode,
                                    SIZE_LONG);
      end else begin
        s_next.src_addr = step_addr(s_reg.src_addr, s_reg.ctrl.src_step_mode,
                                    s_reg.ctrl.unit_size);
      end
      s_next.dst_addr = step_addr(s_reg.dst_addr, s_reg.ctrl.dst_step_mode,
                                  s_reg.ctrl.unit_size);
      s_next.count = s_reg.count - 1'b1;
      if (s_reg.count == CNT_W'(1)) begin
        s_next.ctrl.transfer_end_flag = 1'b1;
        s_next.irq = s_reg.ctrl.end_irq_enable;
      end
    end

    // address error from the bus
    if (bus_addr_err && s_reg.state != ST_IDLE) s_next.addr_error_flag = 1'b1;

    // early stop drops the unit without touching the end flag
    if (s_reg.state != ST_IDLE && !unit_done &&
        (!xfer_ok || bus_addr_err || nmi_s[1])) begin
      s_next.state     = ST_IDLE;
      s_next.bus.valid = 1'b0;
      s_next.bus.write = 1'b0;
    end

    // interrupt line drops when flag or enable clears
    if (!s_next.ctrl.transfer_end_flag || !s_next.ctrl.end_irq_enable) begin
      s_next.irq = 1'b0;
    end

    // standby clears control state like a power-on reset
    if (stb_s[1]) begin
      s_next.ctrl            = CTRL_RESET[$bits(chan_ctrl_t)-1:0];
      s_next.master_enable   = 1'b0;
      s_next.nmi_flag        = 1'b0;
      s_next.addr_error_flag = 1'b0;
      s_next.state           = ST_IDLE;
      s_next.bus             = '0;
      s_next.irq             = 1'b0;
      s_next.req_pend        = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign prdata    = s_reg.prdata;
  assign pready    = s_reg.pready;
  assign pslverr   = s_reg.pslverr;
  assign bus_req   = s_reg.bus;
  assign bus_wdata = s_reg.data;
  assign end_irq   = s_reg.irq;

  ////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_needs_enable: assert property (
    s_reg.state != ST_IDLE |-> $past(s_reg.ctrl.channel_enable))
    else $error("transfer active without channel enable");

  a_end_blocks_start: assert property (
    s_reg.state == ST_IDLE && s_reg.ctrl.transfer_end_flag |=> s_reg.state == ST_IDLE)
    else $error("transfer started with end flag set");

  a_irq_needs_enable: assert property (
    s_reg.irq |-> s_reg.ctrl.end_irq_enable && s_reg.ctrl.transfer_end_flag)
    else $error("interrupt without enable or flag");

  a_end_on_last: assert property (
    unit_done && s_reg.count == CNT_W'(1) && !stb_s[1] |=> s_reg.ctrl.transfer_end_flag)
    else $error("end flag not set on last unit");

  a_count_steps: assert property (
    unit_done && !(wr_acc && s_reg.pready) |=> s_reg.count == $past(s_reg.count) - 1'b1)
    else $error("count did not decrement");

  a_stop_no_end: assert property (
    s_reg.state != ST_IDLE && !unit_done && !s_reg.ctrl.transfer_end_flag && !xfer_ok
    |=> s_reg.state == ST_IDLE && !s_reg.ctrl.transfer_end_flag)
    else $error("early stop misbehaved");

  a_one_write_ignored: assert property (
    s_reg.ctrl.transfer_end_flag && !stb_s[1] && !(wr_acc && !pwdata[TEND_BIT])
    |=> s_reg.ctrl.transfer_end_flag)
    else $error("end flag cleared without 0 write");

  a_auto_starts: assert property (
    s_reg.state == ST_IDLE && xfer_ok && is_auto && !stb_s[1] && !nmi_s[1]
    |=> s_reg.state != ST_IDLE ##0 s_reg.bus.valid)
    else $error("auto-request did not start");

  a_no_src_idle: assert property (
    s_reg.state == ST_IDLE && idx < 0 && !is_auto |=> s_reg.state == ST_IDLE)
    else $error("start with no request source");

  a_flag_halts: assert property (
    s_reg.addr_error_flag || s_reg.nmi_flag |=> s_reg.state == ST_IDLE)
    else $error("transfer continued with error flag");

  a_error_aborts: assert property (
    s_reg.state != ST_IDLE && bus_addr_err && !stb_s[1]
    |=> s_reg.state == ST_IDLE && s_reg.addr_error_flag)
    else $error("address error did not stop the transfer");

  a_standby_clears: assert property (
    stb_s[1]
    |=> !s_reg.ctrl.transfer_end_flag && s_reg.state == ST_IDLE && !s_reg.bus.valid)
    else $error("standby left the channel active");

  a_pointer_long: assert property (
    s_reg.state == ST_PTR |-> s_reg.bus.size == SIZE_LONG && !s_reg.bus.write)
    else $error("pointer fetch not a longword read");

  a_mode_at_start: assert property (
    s_reg.state == ST_IDLE && s_next.state != ST_IDLE
    |=> s_reg.bus.hold == $past(s_reg.ctrl.bus_mode_select))
    else $error("bus mode not taken from the mode bit");

endmodule : dma_channel_control

// file: dma_channel_pkg.sv
package dma_channel_pkg;

  // register byte offsets on apb
  localparam logic [7:0] CTRL_OFS    = 8'h00;  // channel_control
  localparam logic [7:0] SRC_OFS     = 8'h04;  // source address
  localparam logic [7:0] DST_OFS     = 8'h08;  // destination address
  localparam logic [7:0] CNT_OFS     = 8'h0C;  // remaining_count
  localparam logic [7:0] GLOBAL_OFS  = 8'h10;  // global_operation

  // channel_control field positions
  localparam int IND_BIT    = 28;
  localparam int RS_LSB     = 16;
  localparam int SM_LSB     = 12;
  localparam int DM_LSB     = 8;
  localparam int TS_LSB     = 4;
  localparam int BUSMODE_BIT = 3;
  localparam int IRQEN_BIT  = 2;
  localparam int TEND_BIT   = 1;
  localparam int CHEN_BIT   = 0;

  // global_operation field positions
  localparam int AE_BIT     = 2;
  localparam int NMI_BIT    = 1;
  localparam int MEN_BIT    = 0;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int          CNT_W      = 24;
  localparam int          NUM_PERIPH = 26;

  // request source codes
  localparam logic [4:0] RS_NONE   = 5'h00;
  localparam logic [4:0] RS_AUTO   = 5'h1F;

  // address step modes
  localparam logic [1:0] STEP_HOLD = 2'h0;
  localparam logic [1:0] STEP_INC  = 2'h1;
  localparam logic [1:0] STEP_DEC  = 2'h2;

  // unit sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PTR  = 2'b01,
    ST_READ = 2'b10,
    ST_WRITE = 2'b11
  } xfer_state_t;

  // channel control fields
  typedef struct packed {
    logic       indirect_select;
    logic [4:0] req_src_sel;
    logic [1:0] src_step_mode;
    logic [1:0] dst_step_mode;
    logic [1:0] unit_size;
    logic       bus_mode_select;
    logic       end_irq_enable;
    logic       transfer_end_flag;
    logic       channel_enable;
  } chan_ctrl_t;

  // system bus request toward the bus fabric
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [1:0]  size;
    logic        hold;   // burst: keep the bus between units
  } sysbus_req_t;

  typedef struct packed {
    chan_ctrl_t  ctrl;
    logic [31:0] src_addr;
    logic [31:0] dst_addr;
    logic [CNT_W-1:0] count;
    logic        master_enable;
    logic        nmi_flag;
    logic        addr_error_flag;
    logic        tend_seen;   // flag read as 1 since last write
    logic        ae_seen;
    logic        nmi_seen;
    xfer_state_t state;
    logic [31:0] data;
    logic        req_pend;
    sysbus_req_t bus;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } chan_state_t;

endpackage : dma_channel_pkg

// file: dma_bus_partner.sv
`timescale 1ns/100ps
module dma_bus_partner
  import dma_channel_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // system bus from the channel
  input  sysbus_req_t      bus_req,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_done,
  output logic             bus_addr_err,
  output logic      [31:0] bus_rdata,
  // test controls
  input  wire logic [3:0]  wait_cycles,
  input  wire logic        fail_next
);
  logic [31:0] addr_q[$];
  logic [31:0] data_q[$];
  logic        wr_q[$];
  logic        hold_q[$];
  logic [1:0]  size_q[$];
  int          waitc;
  logic        skip;

  //////////////////////////////////////////////////////////////////////////
  // answer a held request after wait_cycles; one quiet edge after each
  // answer so a request that is still standing is never served twice
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_done     <= 1'b0;
      bus_addr_err <= 1'b0;
      bus_rdata    <= 32'h0;
      waitc = 0;
      skip  = 1'b0;
    end else if (bus_done || bus_addr_err) begin
      bus_done     <= 1'b0;
      bus_addr_err <= 1'b0;
      bus_rdata    <= ~bus_rdata;  // released data must not look valid
      skip = 1'b1;
    end else if (skip) begin
      skip = 1'b0;
    end else if (!bus_req.valid) begin
      waitc = 0;
    end else if (waitc < wait_cycles) begin
      waitc++;
    end else if (fail_next) begin
      waitc = 0;
      bus_addr_err <= 1'b1;
    end else begin
      waitc = 0;
      bus_done  <= 1'b1;
      bus_rdata <= bus_req.addr + 32'h0001_0000;  // data tells its address
      addr_q.push_back(bus_req.addr);
      data_q.push_back(bus_wdata);
      wr_q.push_back(bus_req.write);
      hold_q.push_back(bus_req.hold);
      size_q.push_back(bus_req.size);
    end
  end
endmodule : dma_bus_partner

// file: dma_channel_control_test.sv
`timescale 1ns/100ps
module dma_channel_control_test
  import dma_channel_pkg::*;
;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, bus_rdata, bus_wdata;
  logic                  nmi_event, standby, bus_done, bus_addr_err, end_irq;
  logic                  fail_next;
  logic [NUM_PERIPH-1:0] periph_req;
  logic [3:0]            wait_cycles;
  sysbus_req_t           bus_req;
  int                    err_total, compares;

  dma_channel_control #(.CHANNEL(3)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
    .nmi_event(nmi_event), .standby(standby), .bus_req(bus_req),
    .bus_done(bus_done), .bus_addr_err(bus_addr_err),
    .bus_rdata(bus_rdata), .bus_wdata(bus_wdata), .end_irq(end_irq));
  dma_bus_partner partner_u (
    .pclk(pclk), .presetn(presetn), .bus_req(bus_req),
    .bus_wdata(bus_wdata), .bus_done(bus_done), .bus_addr_err(bus_addr_err),
    .bus_rdata(bus_rdata), .wait_cycles(wait_cycles), .fail_next(fail_next));

  //////////////////////////////////////////////////////////////////////////
  // clock
  always #4 pclk = ~pclk;

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // apb transfer; pready, prdata and pslverr taken at the rising edge,
  // before that edge's updates land, and only then is the request dropped
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) err_total++;
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
  endtask : rd

  function automatic logic [31:0] ctl(input logic [4:0] rs, input logic [1:0] sm,
                                      dm, ts, input logic tm, ie, ind);
    ctl = 32'h1;
    ctl[RS_LSB+:5] = rs;
    ctl[SM_LSB+:2] = sm;
    ctl[DM_LSB+:2] = dm;
    ctl[TS_LSB+:2] = ts;
    ctl[BUSMODE_BIT] = tm;
    ctl[IRQEN_BIT] = ie;
    ctl[IND_BIT] = ind;
  endfunction : ctl

  function automatic int nacc();
    return partner_u.addr_q.size();
  endfunction : nacc

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic wait_acc(input int n);
    for (int k = 0; k < 500 && nacc() < n; k++) @(posedge pclk);
    idle(4);
  endtask : wait_acc

  task automatic prog(input logic [31:0] s, d, c, cv);
    wr(SRC_OFS, s);
    wr(DST_OFS, d);
    wr(CNT_OFS, c);
    wr(CTRL_OFS, cv);
  endtask : prog

  // read first so the zero write is honoured; also drops the enable
  task automatic clr_te();
    logic [31:0] r;
    rd(CTRL_OFS, r);
    wr(CTRL_OFS, r & 32'hFFFF_FFFC);
  endtask : clr_te

  task automatic chk_addrs(input int n0, n, input logic [31:0] e [4]);
    for (int i = 0; i < n; i++) check("bus address", partner_u.addr_q[n0+i], e[i]);
  endtask : chk_addrs

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd(CTRL_OFS, r);
    check("ctrl reset", r, CTRL_RESET);
    wr(CTRL_OFS, 32'hFFFF_FFFF);
    rd(CTRL_OFS, r);
    check("ctrl writable", r, 32'h101F_333D);
    idle(10);
    check("master off", nacc(), 0);
    xfer(1'b0, 8'h20, 32'h0, r, e);
    check("unmapped data", r, 32'h0);
    check("unmapped error", e, 1'b1);
    standby <= 1'b1;
    idle(4);
    standby <= 1'b0;
    idle(4);
    rd(CTRL_OFS, r);
    check("standby clear", r, 32'h0);
    wr(GLOBAL_OFS, 32'h1);
  endtask : t_regs

  task automatic t_auto();
    logic [31:0] r;
    int          n0;
    n0 = nacc();
    prog(32'h1000, 32'h2000, 32'h2, ctl(RS_AUTO, STEP_INC, STEP_DEC, SIZE_LONG, 1, 0, 0));
    wait_acc(n0 + 4);
    chk_addrs(n0, 4, '{32'h1000, 32'h2000, 32'h1004, 32'h1FFC});
    check("long data", partner_u.data_q[n0+1], 32'h0001_1000);
    check("burst", partner_u.hold_q[n0], 1'b1);
    check("write dir", partner_u.wr_q[n0+1], 1'b1);
    rd(SRC_OFS, r);
    check("src next", r, 32'h1008);
    rd(DST_OFS, r);
    check("dst next", r, 32'h1FF8);
    rd(CNT_OFS, r);
    check("count", r, 32'h0);
    rd(CTRL_OFS, r);
    check("end flag", r[TEND_BIT], 1'b1);
    check("irq off", end_irq, 1'b0);
    wr(CNT_OFS, 32'h1);
    idle(20);
    check("flag blocks", nacc(), n0 + 4);
    clr_te();
    rd(CTRL_OFS, r);
    check("flag cleared", r[TEND_BIT], 1'b0);
  endtask : t_auto

  task automatic t_ind();
    logic [31:0] r;
    int          n0;
    n0 = nacc();
    prog(32'h7000, 32'h8000, 32'h1, ctl(RS_AUTO, STEP_DEC, STEP_HOLD, SIZE_BYTE, 0, 1, 1));
    wait_acc(n0 + 3);
    chk_addrs(n0, 3, '{32'h7000, 32'h0001_7000, 32'h8000, 32'h0});
    check("steal", partner_u.hold_q[n0], 1'b0);
    check("pointer size", partner_u.size_q[n0], SIZE_LONG);
    check("unit size", partner_u.size_q[n0+1], SIZE_BYTE);
    rd(SRC_OFS, r);
    check("pointer step", r, 32'h6FFC);
    rd(DST_OFS, r);
    check("dst hold", r, 32'h8000);
    check("irq on", end_irq, 1'b1);
    clr_te();
    idle(2);
    check("irq gone", end_irq, 1'b0);
  endtask : t_ind

  task automatic t_periph();
    logic [31:0]           r;
    logic [NUM_PERIPH-1:0] m;
    logic [4:0]            quiet [6];
    int                    n0, idx;
    quiet = '{5'h00, 5'h0D, 5'h0E, 5'h10, 5'h1D, 5'h1E};
    periph_req <= '1;
    foreach (quiet[i]) begin
      n0 = nacc();
      prog(32'h5000, 32'h6000, 32'h1, ctl(quiet[i], 0, 1, 1, 0, 0, 0));
      idle(10);
      check("quiet code", nacc(), n0);
    end
    for (int c = 1; c < 29; c++) begin
      if (c == 13 || c == 14 || c == 16) continue;
      idx = (c <= 12) ? c - 1 : (c == 15) ? 12 : c - 4;
      m = '1;
      m[idx] = 1'b0;
      periph_req <= m;
      n0 = nacc();
      prog(32'h5000, 32'h6000, 32'h1, ctl(5'(c), STEP_HOLD, STEP_INC, SIZE_WORD, 0, 0, 0));
      idle(8);
      check("other lines", nacc(), n0);
      periph_req[idx] <= 1'b1;
      wait_acc(n0 + 2);
      check("own line", nacc(), n0 + 2);
      rd(DST_OFS, r);
      check("word step", r, 32'h6002);
      periph_req <= '0;
      clr_te();
    end
  endtask : t_periph

  task automatic t_stop();
    logic [31:0] r;
    int          n0;
    n0 = nacc();
    wait_cycles <= 4'h8;  // slow bus so the disable lands mid-unit
    prog(32'h9000, 32'hA000, 32'h3, ctl(RS_AUTO, 1, 1, 2, 0, 0, 0));
    wait_acc(n0 + 1);
    wr(CTRL_OFS, ctl(RS_AUTO, 1, 1, 2, 0, 0, 0) & 32'hFFFF_FFFE);
    idle(40);
    check("disable stops", nacc() <= n0 + 2, 1'b1);
    rd(CTRL_OFS, r);
    check("no flag", r[TEND_BIT], 1'b0);
    wait_cycles <= 4'h0;
    fail_next <= 1'b1;
    n0 = nacc();
    prog(32'hB000, 32'hC000, 32'h2, ctl(RS_AUTO, 1, 1, 2, 0, 0, 0));
    idle(20);
    fail_next <= 1'b0;
    rd(GLOBAL_OFS, r);
    check("addr error", r[AE_BIT], 1'b1);
    rd(CTRL_OFS, r);
    check("no flag on error", r[TEND_BIT], 1'b0);
    idle(20);
    check("held by error", nacc(), n0);
    wr(GLOBAL_OFS, 32'h1);
    wait_acc(n0 + 4);
    check("resumes", nacc(), n0 + 4);
    clr_te();
    nmi_event <= 1'b1;
    idle(3);
    nmi_event <= 1'b0;
    rd(GLOBAL_OFS, r);
    check("nmi flag", r[NMI_BIT], 1'b1);
    n0 = nacc();
    prog(32'hD000, 32'hE000, 32'h1, ctl(RS_AUTO, 1, 1, 2, 0, 0, 0));
    idle(20);
    check("held by nmi", nacc(), n0);
    wr(GLOBAL_OFS, 32'h1);
    wait_acc(n0 + 2);
    check("nmi cleared", nacc(), n0 + 2);
    clr_te();
  endtask : t_stop

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, nmi_event, standby, fail_next} = '0;
    {paddr, pwdata, periph_req, wait_cycles} = '0;
    err_total = 0;
    compares = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_auto();
    t_ind();
    t_periph();
    t_stop();
    results();
  end

  // watchdog, far beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    results();
  end
endmodule : dma_channel_control_test
